// ==== design/mrsf_pkg.sv ====
// ****************************************
// Frame constants
// ****************************************
package mrsf_pkg;

  localparam int unsigned CLK_HZ              = 125_000_000;
  localparam int unsigned BAUD_DEFAULT        = 9600;
  localparam int unsigned CHAR_BITS           = 11;
  // Idle gap of 3.5 character times, kept in tenths
  localparam int unsigned FRAME_GAP_CHARS_X10 = 35;
  localparam int unsigned CHAR_CYCLES         = (CLK_HZ * CHAR_BITS + BAUD_DEFAULT - 1) / BAUD_DEFAULT;
  localparam int unsigned FRAME_GAP_CYCLES    = (CHAR_CYCLES * FRAME_GAP_CHARS_X10 + 9) / 10;

  localparam logic [7:0]  ADDR_BCAST       = 8'h00;
  localparam logic [7:0]  ADDR_MAX         = 8'hF7;
  localparam logic [7:0]  FC_READ_HOLD     = 8'h03;
  localparam logic [7:0]  FC_WRITE_ONE     = 8'h06;
  localparam logic [7:0]  FC_DIAG          = 8'h08;
  localparam logic [7:0]  FC_WRITE_MULTI   = 8'h10;
  localparam logic [7:0]  FC_ACCESS_LOG    = 8'h46;
  localparam logic [7:0]  FC_ERR_FLAG      = 8'h80;
  localparam logic [7:0]  EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [15:0] CRC_PRESET       = 16'hFFFF;
  localparam logic [15:0] CRC_POLY         = 16'hA001;
  localparam logic [8:0]  MIN_FRAME_LEN    = 9'h004;
  localparam logic [8:0]  LEN_MAX          = 9'h1FF;
  localparam int unsigned TX_FIFO_DEPTH    = 16;

  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_RECV  = 9'h002,
    ST_CHECK = 9'h004,
    ST_EXEC  = 9'h008,
    ST_HDR_A = 9'h010,
    ST_HDR_F = 9'h020,
    ST_BODY  = 9'h040,
    ST_CRC_L = 9'h080,
    ST_CRC_H = 9'h100
  } mrsf_state_t;

  // One byte of the check value, LSB first, reflected polynomial
  function automatic logic [15:0] mrsf_crc_step(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

// ==== design/mrsf_strm_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Byte stream into the transmit buffer
// ****************************************
interface mrsf_strm_if #(
  parameter int unsigned W = 8
);
  logic         valid;
  logic         ready;
  logic         room2;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready, input room2);
  modport snk (input valid, input data, output ready, output room2);
endinterface
`default_nettype wire

// ==== design/mrsf_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Transmit FIFO, registered read port
// ****************************************
module mrsf_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  mrsf_strm_if.snk          wr,
  output logic [W-1:0]      rd_data,
  output logic              rd_valid,
  input  wire logic         rd_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW:0]   cnt_q;
  logic [AW:0]   cnt_d;
  logic          push;
  logic          load;

  assign wr.ready = (cnt_q < (AW+1)'(DEPTH));
  // Room for two lets the source register its ready a cycle early
  assign wr.room2 = (cnt_q <= (AW+1)'(DEPTH - 2));
  assign push     = wr.valid && wr.ready;
  assign load     = (cnt_q != '0) && (!rd_valid || rd_ready);
  assign cnt_d    = cnt_q + (AW+1)'(push) - (AW+1)'(load);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_q] <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wptr_q   <= '0;
      rptr_q   <= '0;
      cnt_q    <= '0;
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else begin
      cnt_q <= cnt_d;
      if (push) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (load) begin
        rptr_q   <= rptr_q + 1'b1;
        rd_data  <= mem[rptr_q];
        rd_valid <= 1'b1;
      end else if (rd_ready) begin
        rd_valid <= 1'b0;
      end
    end
  end

  AST_FIFO_NO_OVERFLOW:
    assert property (@(posedge clk) disable iff (!rst_n) cnt_q <= (AW+1)'(DEPTH))
    else $error("transmit fifo count above depth");
endmodule
`default_nettype wire

// ==== design/mrsf_frame.sv ====
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Address byte 0 broadcast, 1..247 single slave
// - Own address is the station number setting
// - Response echoes the query address
// - Function byte carries any code 1..255
// - Unsupported function gets an error response
// - Normal response echoes function code unchanged
// - Error response returns function plus 80h
// - Code 03 read, refused as broadcast
// - Code 06 single write, broadcast allowed
// - Code 08 diagnostic, refused as broadcast
// - Code 10 multi write, broadcast allowed
// - Code 46 access log, refused as broadcast
// - Check value appended, low byte first
// - Receiver recomputes and compares check value
// - Check mismatch makes the whole message bad
// - Frames delimited by 3.5 character idle gap
// - No reply on byte error or bad check
// - Broadcast executed, never answered
module mrsf_frame
  import mrsf_pkg::*;
#(
  parameter int unsigned GAP_CYCLES = FRAME_GAP_CYCLES,
  parameter int unsigned FIFO_DEPTH = TX_FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] station_number_setting,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_err,
  output logic            q_valid_q,
  output logic [7:0]      q_data_q,
  output logic [8:0]      q_index_q,
  output logic            exec_valid_q,
  output logic [7:0]      exec_func_q,
  output logic            exec_bcast_q,
  output logic [8:0]      exec_len_q,
  output logic            frame_drop_q,
  input  wire logic       done,
  input  wire logic       done_exc,
  input  wire logic [7:0] done_exc_code,
  input  wire logic       pl_valid,
  input  wire logic [7:0] pl_data,
  input  wire logic       pl_last,
  output logic            pl_ready_q,
  output logic            tx_valid,
  output logic [7:0]      tx_data,
  input  wire logic       tx_ready
);
  localparam int unsigned GW = $clog2(GAP_CYCLES + 1);

  // ****************************************
  // Declarations
  // ****************************************
  mrsf_state_t st_q;
  mrsf_state_t st_d;
  logic [GW-1:0] gap_cnt_q;
  logic [8:0]    len_q;
  logic [7:0]    addr_q;
  logic [7:0]    func_q;
  logic [7:0]    last_q;
  logic [7:0]    prev_q;
  logic [15:0]   crc_q;
  logic [15:0]   crc_p1_q;
  logic [15:0]   crc_p2_q;
  logic          err_q;
  logic          exc_q;
  logic [7:0]    exc_code_q;
  logic [15:0]   tx_crc_q;

  mrsf_strm_if #(.W(8)) txw ();

  // ****************************************
  // Decode
  // ****************************************
  wire        gap_done    = (gap_cnt_q == GW'(GAP_CYCLES));
  wire        st_idle     = (st_q == ST_IDLE);
  wire        st_recv     = (st_q == ST_RECV);
  wire        st_check    = (st_q == ST_CHECK);
  wire        st_exec     = (st_q == ST_EXEC);
  wire        st_body     = (st_q == ST_BODY);
  wire        st_crc      = (st_q == ST_CRC_L) || (st_q == ST_CRC_H);
  wire        frame_start = rx_valid && st_idle && gap_done;
  wire        frame_byte  = frame_start || (rx_valid && st_recv);
  wire [15:0] crc_base    = st_idle ? CRC_PRESET : crc_q;
  wire [15:0] crc_next    = mrsf_crc_step(crc_base, rx_data);
  wire [15:0] crc_rx      = {last_q, prev_q};
  wire        crc_ok      = (crc_p2_q == crc_rx);
  wire        frame_good  = !err_q && crc_ok && (len_q >= MIN_FRAME_LEN);
  wire        addr_bcast  = (addr_q == ADDR_BCAST);
  wire        addr_mine   = (addr_q == station_number_setting) && !addr_bcast && (addr_q <= ADDR_MAX);
  wire        fc_bcast_ok = (func_q == FC_WRITE_ONE) || (func_q == FC_WRITE_MULTI);
  wire        fc_supported = fc_bcast_ok || (func_q == FC_READ_HOLD) || (func_q == FC_DIAG)
                             || (func_q == FC_ACCESS_LOG);
  wire        dec_drop    = !frame_good || !(addr_bcast || addr_mine) || (addr_bcast && !fc_bcast_ok);
  wire        dec_exec    = !dec_drop && fc_supported;
  wire        dec_err     = !dec_drop && !fc_supported;
  wire        pl_fire     = pl_valid && pl_ready_q && !exc_q && st_body;
  wire        push_req    = (st_q == ST_HDR_A) || (st_q == ST_HDR_F) || st_crc
                            || (st_body && (exc_q || pl_fire));
  wire        push_fire   = push_req && txw.ready;
  wire [7:0]  func_echo   = exc_q ? (func_q | FC_ERR_FLAG) : func_q;
  wire [7:0]  body_byte   = exc_q ? exc_code_q : pl_data;

  logic [7:0] tx_byte;
  always_comb begin
    tx_byte = 8'h00;
    case (st_q)
      ST_HDR_A: tx_byte = addr_q;
      ST_HDR_F: tx_byte = func_echo;
      ST_BODY:  tx_byte = body_byte;
      ST_CRC_L: tx_byte = tx_crc_q[7:0];
      ST_CRC_H: tx_byte = tx_crc_q[15:8];
      default:  tx_byte = 8'h00;
    endcase
  end

  assign txw.valid = push_req;
  assign txw.data  = tx_byte;

  // ****************************************
  // Idle gap timer
  // ****************************************
  // Cleared at reset so the first frame also waits a full gap
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gap_cnt_q <= '0;
    end else if (rx_valid) begin
      gap_cnt_q <= '0;
    end else if (!gap_done) begin
      gap_cnt_q <= gap_cnt_q + 1'b1;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:  if (frame_start) st_d = ST_RECV;
      ST_RECV:  if (gap_done && !rx_valid) st_d = ST_CHECK;
      ST_CHECK: begin
        if (dec_exec) begin
          st_d = ST_EXEC;
        end else if (dec_err) begin
          st_d = ST_HDR_A;
        end else begin
          st_d = ST_IDLE;
        end
      end
      ST_EXEC:  if (done) st_d = exec_bcast_q ? ST_IDLE : ST_HDR_A;
      ST_HDR_A: if (push_fire) st_d = ST_HDR_F;
      ST_HDR_F: if (push_fire) st_d = ST_BODY;
      ST_BODY:  if (push_fire && (exc_q || pl_last)) st_d = ST_CRC_L;
      ST_CRC_L: if (push_fire) st_d = ST_CRC_H;
      ST_CRC_H: if (push_fire) st_d = ST_IDLE;
      default:  st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Receive path
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      len_q    <= '0;
      addr_q   <= 8'h00;
      func_q   <= 8'h00;
      last_q   <= 8'h00;
      prev_q   <= 8'h00;
      crc_q    <= CRC_PRESET;
      crc_p1_q <= CRC_PRESET;
      crc_p2_q <= CRC_PRESET;
      err_q    <= 1'b0;
    end else if (frame_byte) begin
      crc_q    <= crc_next;
      crc_p1_q <= crc_base;
      crc_p2_q <= st_idle ? CRC_PRESET : crc_p1_q;
      last_q   <= rx_data;
      prev_q   <= st_idle ? 8'h00 : last_q;
      len_q    <= st_idle ? 9'h001 : ((len_q == LEN_MAX) ? len_q : len_q + 1'b1);
      err_q    <= (st_idle ? 1'b0 : err_q) | rx_err;
      if (st_idle) begin
        addr_q <= rx_data;
      end
      if (st_recv && (len_q == 9'h001)) begin
        func_q <= rx_data;
      end
    end
  end

  // Query bytes after the function field, check bytes included
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_valid_q <= 1'b0;
      q_data_q  <= 8'h00;
      q_index_q <= '0;
    end else begin
      q_valid_q <= frame_byte && st_recv && (len_q >= 9'h002);
      q_data_q  <= rx_data;
      q_index_q <= len_q;
    end
  end

  // ****************************************
  // Execute handshake and answer choice
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      exec_valid_q <= 1'b0;
      exec_func_q  <= 8'h00;
      exec_bcast_q <= 1'b0;
      exec_len_q   <= '0;
      frame_drop_q <= 1'b0;
      exc_q        <= 1'b0;
      exc_code_q   <= 8'h00;
    end else begin
      exec_valid_q <= st_check && dec_exec;
      frame_drop_q <= st_check && !frame_good;
      if (st_check) begin
        exec_func_q  <= func_q;
        exec_bcast_q <= addr_bcast;
        exec_len_q   <= len_q;
        exc_q        <= dec_err;
        exc_code_q   <= EXC_ILLEGAL_FUNC;
      end else if (st_exec && done) begin
        exc_q        <= done_exc;
        exc_code_q   <= done_exc_code;
      end
    end
  end

  // ****************************************
  // Transmit path
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_crc_q <= CRC_PRESET;
    end else if (st_check || st_exec) begin
      tx_crc_q <= CRC_PRESET;
    end else if (push_fire && !st_crc) begin
      tx_crc_q <= mrsf_crc_step(tx_crc_q, tx_byte);
    end
  end

  // Registered ready is safe: room for two was seen a cycle before
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pl_ready_q <= 1'b0;
    end else begin
      pl_ready_q <= (st_d == ST_BODY) && !exc_q && txw.room2 && !(pl_fire && pl_last);
    end
  end

  mrsf_fifo #(
    .W     (8),
    .DEPTH (FIFO_DEPTH)
  ) u_txfifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .wr       (txw),
    .rd_data  (tx_data),
    .rd_valid (tx_valid),
    .rd_ready (tx_ready)
  );

  // ****************************************
  // Checks
  // ****************************************
  AST_ADDR_ECHO:
    assert property (@(posedge clk) disable iff (!rst_n)
      (st_q == ST_HDR_A) && push_fire |-> txw.data == addr_q && !addr_bcast)
    else $error("response address differs from query");
  AST_FUNC_NORMAL:
    assert property (@(posedge clk) disable iff (!rst_n)
      (st_q == ST_HDR_F) && push_fire && !exc_q |-> txw.data == exec_func_q)
    else $error("normal response function changed");
  AST_FUNC_ERROR:
    assert property (@(posedge clk) disable iff (!rst_n)
      (st_q == ST_HDR_F) && push_fire && exc_q |-> txw.data == (func_q | 8'h80))
    else $error("error response lacks top bit");
  AST_UNSUPPORTED:
    assert property (@(posedge clk) disable iff (!rst_n)
      st_check && frame_good && addr_mine && !fc_supported |=> exc_q && st_q == ST_HDR_A && !exec_valid_q)
    else $error("unsupported code not answered with error");
  AST_BCAST_REFUSED:
    assert property (@(posedge clk) disable iff (!rst_n)
      st_check && addr_bcast && (func_q == FC_READ_HOLD || func_q == FC_DIAG || func_q == FC_ACCESS_LOG)
      |=> !exec_valid_q && st_idle)
    else $error("read type broadcast accepted");
  AST_BCAST_WRITE:
    assert property (@(posedge clk) disable iff (!rst_n)
      st_check && frame_good && addr_bcast && fc_bcast_ok |=> exec_valid_q && exec_bcast_q)
    else $error("broadcast write not executed");
  AST_BCAST_SILENT:
    assert property (@(posedge clk) disable iff (!rst_n)
      st_exec && exec_bcast_q && done |=> st_idle ##1 !push_req)
    else $error("broadcast answered");
  AST_BAD_CHECK:
    assert property (@(posedge clk) disable iff (!rst_n)
      st_check && (!crc_ok || err_q) |=> frame_drop_q && st_idle && !exec_valid_q)
    else $error("bad frame not dropped");
  AST_FOREIGN:
    assert property (@(posedge clk) disable iff (!rst_n)
      st_check && !addr_bcast && (addr_q != station_number_setting || addr_q > 8'hF7)
      |=> st_idle && !exec_valid_q)
    else $error("foreign frame accepted");
  AST_GAP_END:
    assert property (@(posedge clk) disable iff (!rst_n)
      st_recv && !gap_done |=> !st_check)
    else $error("frame closed before idle gap");
  AST_CRC_ORDER:
    assert property (@(posedge clk) disable iff (!rst_n)
      (st_q == ST_CRC_L) && push_fire |=> (st_q == ST_CRC_H) && txw.data == $past(tx_crc_q[15:8]))
    else $error("check bytes out of order");
  AST_BODY_ROOM:
    assert property (@(posedge clk) disable iff (!rst_n) pl_fire |-> txw.ready)
    else $error("payload accepted without buffer room");
  AST_DROP_SILENT:
    assert property (@(posedge clk) disable iff (!rst_n)
      frame_drop_q |-> st_idle && !push_req)
    else $error("dropped frame answered");
  AST_OWN_EXEC:
    assert property (@(posedge clk) disable iff (!rst_n)
      st_check && frame_good && !addr_bcast && (addr_q == station_number_setting) && (addr_q <= ADDR_MAX)
      && fc_supported |=> exec_valid_q)
    else $error("own supported frame not executed");
  AST_CRC_LOW:
    assert property (@(posedge clk) disable iff (!rst_n)
      (st_q == ST_CRC_L) && push_fire |-> txw.data == tx_crc_q[7:0])
    else $error("check low byte wrong");
endmodule
`default_nettype wire

// ==== test/mrsf_master_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Serial master model
// ****************************************
module mrsf_master_model #(
  parameter int unsigned GAP = 20
) (
  input  wire logic       clk,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_err,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  // Mode 0 prompt, 1 every other cycle, 2 stalled
  logic [1:0] mode;
  logic [7:0] got[$];

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_err   = 1'b0;
    tx_ready = 1'b0;
  end

  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
    tx_ready <= (mode == 2'h0) || ((mode == 2'h1) && !tx_ready);
  end

  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction

  // Bad check value flips bit 0 so the frame is still well formed
  task automatic send(input logic [7:0] a, input logic [7:0] f, input bit bad, input bit err, input bit nogap);
    logic [7:0]  b[$];
    logic [15:0] c;
    b = '{a, f, 8'h12, 8'h34};
    c = crc16(b) ^ {15'h0000, bad};
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    if (!nogap) repeat (GAP + 3) @(posedge clk);
    foreach (b[i]) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data  <= b[i];
      rx_err   <= err && (i == 3);
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data  <= ~b[5];
    rx_err   <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== test/mrsf_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Frame handling testbench
// ****************************************
module testbench;
  import mrsf_pkg::*;
  localparam int unsigned GAP = 20;
  typedef struct packed {
    logic [7:0] st;
    logic [7:0] a;
    logic [7:0] f;
    logic [3:0] flag;
    logic [3:0] kind;
  } mrsf_row_t;
  // Kind 0 silent, 1 normal, 2 illegal code, 3 broadcast run, 4 dropped
  mrsf_row_t rows [18] = '{32'h05050301, 32'h05050601, 32'h05050801, 32'h05051001, 32'h05054601,
    32'h05050102, 32'h0505FF02, 32'h05000603, 32'h05001003, 32'h05000300, 32'h05000800,
    32'h05004600, 32'h05060300, 32'hF7F70301, 32'hF8F80300, 32'h05050314, 32'h05050624, 32'h05000614};

  logic       clk;
  logic       rst_n;
  logic [7:0] station_number_setting;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       rx_err;
  logic       q_valid_q;
  logic [7:0] q_data_q;
  logic [8:0] q_index_q;
  logic       exec_valid_q;
  logic [7:0] exec_func_q;
  logic       exec_bcast_q;
  logic [8:0] exec_len_q;
  logic       frame_drop_q;
  logic       done;
  logic       done_exc;
  logic [7:0] done_exc_code;
  logic       pl_valid;
  logic [7:0] pl_data;
  logic       pl_last;
  logic       pl_ready_q;
  logic       tx_valid;
  logic [7:0] tx_data;
  logic       tx_ready;
  int         miscompares;
  int         total_checks;
  int         n_exec;
  int         n_drop;
  int         n_q;
  int         n_stall;
  logic [15:0] q_log [$];

  mrsf_frame #(.GAP_CYCLES(GAP), .FIFO_DEPTH(16)) DUT (.clk(clk), .rst_n(rst_n),
    .station_number_setting(station_number_setting), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_err(rx_err), .q_valid_q(q_valid_q), .q_data_q(q_data_q), .q_index_q(q_index_q),
    .exec_valid_q(exec_valid_q), .exec_func_q(exec_func_q), .exec_bcast_q(exec_bcast_q),
    .exec_len_q(exec_len_q), .frame_drop_q(frame_drop_q), .done(done), .done_exc(done_exc),
    .done_exc_code(done_exc_code), .pl_valid(pl_valid), .pl_data(pl_data), .pl_last(pl_last),
    .pl_ready_q(pl_ready_q), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

  mrsf_master_model #(.GAP(GAP)) u_master (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_err(rx_err), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

  always #4 clk = ~clk;

  always @(posedge clk) begin
    n_exec  += int'(exec_valid_q);
    n_drop  += int'(frame_drop_q);
    n_q     += int'(q_valid_q);
    // Payload taken while the far side refuses every byte
    n_stall += int'(pl_valid && pl_ready_q && u_master.mode == 2'h2);
    if (q_valid_q) begin
      q_log.push_back({q_index_q[7:0], q_data_q});
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic bail();
    miscompares++;
    $display("BAD t=%0t wait ran out", $time);
    report_and_stop();
  endtask

  // One query, handler answer, then the whole reply compared byte by byte
  task automatic frame(input mrsf_row_t r, input bit exc, input logic [7:0] code, input int npl);
    int          e0;
    int          d0;
    int          q0;
    int          k;
    logic [7:0]  exp[$];
    logic [15:0] c;
    e0 = n_exec;
    d0 = n_drop;
    q0 = n_q;
    q_log.delete();
    station_number_setting <= r.st;
    u_master.send(r.a, r.f, r.flag[0], r.flag[1], 1'b0);
    repeat (GAP + 4) @(posedge clk);
    check(16'(n_exec - e0), 16'(r.kind == 4'h1 || r.kind == 4'h3), "exec");
    check(16'(n_drop - d0), 16'(r.kind == 4'h4), "drop");
    if (r.kind == 4'h1 || r.kind == 4'h3) begin
      check(exec_func_q, r.f, "func");
      check(exec_bcast_q, r.a == 8'h00, "bcast");
      check(exec_len_q, 16'h0006, "length");
      @(posedge clk);
      done          <= 1'b1;
      done_exc      <= exc;
      done_exc_code <= code;
      @(posedge clk);
      done     <= 1'b0;
      done_exc <= 1'b0;
    end
    if (r.kind == 4'h1) begin
      check(16'(n_q - q0), 16'h0004, "forwarded");
      check(q_log[0], 16'h0212, "query byte");
      check(q_log[1], 16'h0334, "query byte");
      for (int i = 0; i < npl && !exc; i++) begin
        pl_valid <= 1'b1;
        pl_data  <= 8'hA0 + 8'(i);
        pl_last  <= (i == npl - 1);
        k = 0;
        do begin
          @(posedge clk);
          k++;
        end while (!pl_ready_q && k < 400);
        if (k >= 400) bail();
      end
      pl_valid <= 1'b0;
      pl_last  <= 1'b0;
      exp = '{r.a, exc ? (r.f | 8'h80) : r.f};
      if (exc) exp.push_back(code);
      for (int i = 0; i < npl && !exc; i++) exp.push_back(8'hA0 + 8'(i));
    end else if (r.kind == 4'h2) begin
      exp = '{r.a, r.f | 8'h80, 8'h01};
    end
    if (exp.size() != 0) begin
      c = u_master.crc16(exp);
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
    end
    k = 0;
    while (u_master.got.size() < exp.size() && k < 600) begin
      @(posedge clk);
      k++;
    end
    if (k >= 600) bail();
    repeat (20) @(posedge clk);
    check(16'(u_master.got.size()), 16'(exp.size()), "reply length");
    foreach (exp[i]) begin
      if (i < u_master.got.size()) check(u_master.got[i], exp[i], "reply byte");
    end
    u_master.got.delete();
  endtask

  initial begin
    clk                    = 1'b0;
    rst_n                  = 1'b0;
    station_number_setting = 8'h05;
    done                   = 1'b0;
    done_exc               = 1'b0;
    done_exc_code          = 8'h00;
    pl_valid               = 1'b0;
    pl_data                = 8'h00;
    pl_last                = 1'b0;
    u_master.mode          = 2'h0;
    repeat (4) @(posedge clk);
    check({tx_valid, exec_valid_q, pl_ready_q, q_valid_q, frame_drop_q}, 16'h0000, "reset");
    rst_n <= 1'b1;
    // ****************************************
    // Frame with no leading gap
    // ****************************************
    u_master.send(8'h05, 8'h03, 1'b0, 1'b0, 1'b1);
    repeat (GAP + 30) @(posedge clk);
    check(16'(n_exec), 16'h0000, "no gap");
    check(16'(u_master.got.size()), 16'h0000, "no gap reply");
    // ****************************************
    // Table of frames
    // ****************************************
    foreach (rows[i]) begin
      u_master.mode <= 2'(i % 2);
      frame(rows[i], 1'b0, 8'h00, 2);
    end
    // ****************************************
    // Handler refusal and full buffer
    // ****************************************
    frame(32'h05050601, 1'b1, 8'h03, 0);
    n_stall = 0;
    u_master.mode <= 2'h2;
    fork
      begin
        repeat (GAP + 100) @(posedge clk);
        u_master.mode <= 2'h0;
      end
    join_none
    frame(32'h05050301, 1'b0, 8'h00, 20);
    // Buffer and its output register hold DEPTH+1 bytes, the header takes two
    check(16'(n_stall), 16'(TX_FIFO_DEPTH - 1), "buffer stall");
    report_and_stop();
  end
endmodule
`default_nettype wire
